// ===== common/keypad_menu_pkg.sv
// constants and types for the front-panel keypad and menu logic
// assumes a 10 MHz system clock and keys sampled as synchronous levels
package keypad_menu_pkg;
  typedef enum logic [1:0] {MODE_REG, MODE_STOP, MODE_HAND, MODE_COMM} op_mode_t;
  typedef enum logic [2:0] {RB_PF, RB_VOLT, RB_CURR, RB_HAND, RB_INFO, RB_EDIT} ribbon_t;
  typedef enum logic [1:0] {ED_NONE, ED_NUM, ED_LIST} edit_t;
  localparam int CLK_HZ = 10_000_000;
  localparam int LONG_S = 3;
  localparam int TMO_MIN = 3;
  localparam int LONG_CYC = CLK_HZ * LONG_S;
  localparam int TMO_CYC = CLK_HZ * 60 * TMO_MIN;
  localparam logic [3:0] K_ABORT = 4'h1;
  localparam logic [3:0] K_DOWN = 4'h2;
  localparam logic [3:0] K_RIGHT = 4'h4;
  localparam logic [3:0] K_SET = 4'h8;
  localparam logic [3:0] CHORD_STOP = 4'h9;
  localparam logic [3:0] CHORD_RESET = 4'h6;
  localparam logic [2:0] code_table_readings_group = 3'h0;
  localparam logic [2:0] GRP_STEPS = 3'h3;
  localparam logic [2:0] GRP_LAST = 3'h4;
  localparam logic [2:0] SER_LAST_1D = 3'h7;
  localparam logic [2:0] SER_LAST_2D = 3'h3;
  localparam logic [3:0] ITEM_LAST = 4'h7;
  localparam logic [3:0] STEP_FIRST = 4'h1;
  localparam logic [3:0] STEP_LAST = 4'h8;
  localparam logic [3:0] STEP_ALL = 4'h0;
  localparam logic [3:0] DIG_DEC_MAX = 4'h9;
  localparam logic [3:0] DIG_HEX_MAX = 4'hF;
  localparam logic [3:0] PF_INT_MAX = 4'h1;
  localparam logic [7:0] PF_FRAC_HI = 8'h99;
  localparam logic [1:0] DIG_PF_INT = 2'h2;
  localparam logic [15:0] VAL_RST = 16'h0000;
endpackage

// ===== verification/keypad_menu_number_entry_bench.sv
// self-checking bench for the keypad, menu cursor and editors
// assumes short long-press and idle counts set through the parameters
`timescale 1ns/1ps
module keypad_menu_number_entry_bench;
  import keypad_menu_pkg::*;
  logic clk_sys, rstn, go, busy;
  logic [3:0] keys;
  logic [7:0] hold;
  logic abort_key, down_key, right_key, set_key;
  logic hand_enter, comm_start, comm_done, longterm_busy, result_busy;
  logic edit_list, edit_hex, edit_pf, edit_pair, round_en;
  logic [15:0] val_min, val_max, disp_val, stored_a, stored_b;
  logic [3:0] list_len, menu_item, digit_blink;
  op_mode_t op_mode;
  ribbon_t ribbon_pos;
  logic [1:0] menu_level;
  logic [2:0] menu_group, menu_series;
  logic on_upper_ribbon, info_led_blink, steps_all, edit_active, whole_blink, dp_off;
  logic basis_two_dec, pair_pending, estop_pulse, reset_pulse, reject_pulse;
  int bad_count = 0, total_checks = 0, cyc = 0, n_stop = 0, n_rst = 0, n_rej = 0;

  keypad_operator op (.clk_sys(clk_sys), .go(go), .keys(keys), .hold(hold), .busy(busy),
    .abort_key(abort_key), .down_key(down_key), .right_key(right_key), .set_key(set_key));
  keypad_menu_number_entry #(.LONG_CYCLES(20), .TMO_CYCLES(200)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .abort_key(abort_key), .down_key(down_key),
    .right_key(right_key), .set_key(set_key), .hand_enter(hand_enter),
    .comm_start(comm_start), .comm_done(comm_done), .longterm_busy(longterm_busy),
    .result_busy(result_busy), .edit_list(edit_list), .edit_hex(edit_hex),
    .edit_pf(edit_pf), .edit_pair(edit_pair), .round_en(round_en), .val_min(val_min),
    .val_max(val_max), .list_len(list_len), .op_mode(op_mode), .ribbon_pos(ribbon_pos),
    .menu_level(menu_level), .menu_group(menu_group), .menu_series(menu_series),
    .menu_item(menu_item), .on_upper_ribbon(on_upper_ribbon),
    .info_led_blink(info_led_blink), .steps_all(steps_all), .edit_active(edit_active),
    .disp_val(disp_val), .digit_blink(digit_blink), .whole_blink(whole_blink),
    .dp_off(dp_off), .basis_two_dec(basis_two_dec), .stored_a(stored_a),
    .stored_b(stored_b), .pair_pending(pair_pending), .estop_pulse(estop_pulse),
    .reset_pulse(reset_pulse), .reject_pulse(reject_pulse));

  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // pulses last one cycle, so they are counted here rather than polled
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (estop_pulse === 1'h1) n_stop <= n_stop + 1;
    if (reset_pulse === 1'h1) n_rst <= n_rst + 1;
    if (reject_pulse === 1'h1) n_rej <= n_rej + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic press(input logic [3:0] k, input logic [7:0] h);
    int w;
    w = 0;
    keys = k;
    hold = h;
    go = 1'h1;
    @(posedge clk_sys);
    #1 go = 1'h0;
    do begin
      @(posedge clk_sys);
      w++;
    end while (busy && w < 300);
    #1;
    if (w >= 300) chk("operator busy", 16'(busy), 16'h0);
  endtask

  task automatic taps(input logic [3:0] k, input int n);
    repeat (n) press(k, 8'h02);
  endtask

  task automatic strobe(input logic [2:0] w);
    {comm_done, comm_start, hand_enter} = w;
    @(posedge clk_sys);
    #1 {comm_done, comm_start, hand_enter} = 3'h0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset;
    chk("mode", 16'(op_mode), 16'(MODE_REG));
    chk("ribbon", 16'(ribbon_pos), 16'(RB_PF));
    chk("basis", 16'(basis_two_dec), 16'h1);
    taps(K_DOWN, 2);
    chk("curr blink", 16'(whole_blink), 16'h1);
    taps(K_ABORT, 1);
    chk("abort std", 16'(ribbon_pos), 16'(RB_PF));
    $display("test reset done");
  endtask

  task automatic t_chord;
    taps(K_DOWN, 1);
    press(CHORD_STOP, 8'h0a);
    chk("short stop", 16'(n_stop), 16'h0);
    chk("no single", 16'(ribbon_pos), 16'(RB_VOLT));
    press(CHORD_STOP, 8'h1e);
    chk("stop pulse", 16'(n_stop), 16'h1);
    chk("stop mode", 16'(op_mode), 16'(MODE_STOP));
    chk("stop std", 16'(ribbon_pos), 16'(RB_PF));
    press(CHORD_RESET, 8'h1e);
    chk("rst pulse", 16'(n_rst), 16'h1);
    chk("rst mode", 16'(op_mode), 16'(MODE_REG));
    $display("test chord done");
  endtask

  task automatic t_info;
    taps(K_DOWN, 4);
    taps(K_RIGHT, 1);
    chk("led", 16'(info_led_blink), 16'h1);
    taps(K_RIGHT, 4);
    chk("group", 16'(menu_group), 16'(GRP_LAST));
    taps(K_RIGHT, 1);
    chk("upper1", 16'(on_upper_ribbon), 16'h1);
    taps(K_RIGHT, 4);
    taps(K_DOWN, 1);
    taps(K_RIGHT, 1);
    chk("item1", 16'(menu_item), 16'(STEP_FIRST));
    taps(K_RIGHT, 8);
    chk("all", 16'(steps_all), 16'h1);
    taps(K_RIGHT, 1);
    taps(K_DOWN, 1);
    chk("series", 16'(menu_series), 16'h1);
    chk("item kept", 16'(menu_item), 16'(STEP_FIRST));
    taps(K_ABORT, 1);
    chk("lvl2", 16'(menu_level), 16'h2);
    taps(K_DOWN, 3);
    chk("upper2", 16'(on_upper_ribbon), 16'h1);
    taps(K_ABORT, 3);
    chk("std", 16'(ribbon_pos), 16'(RB_PF));
    chk("led off", 16'(info_led_blink), 16'h0);
    chk("ro", stored_a, 16'h0);
    $display("test info done");
  endtask

  task automatic t_edit;
    taps(K_DOWN, 5);
    taps(K_SET, 1);
    chk("blink3", 16'(digit_blink), 16'h8);
    taps(K_DOWN, 1);
    chk("wrap9", disp_val, 16'h9000);
    taps(K_RIGHT, 1);
    chk("blink2", 16'(digit_blink), 16'h4);
    taps(K_SET, 1);
    chk("store", stored_a, 16'h9000);
    round_en = 1'h1;
    taps(K_SET, 1);
    taps(K_RIGHT, 3);
    taps(K_DOWN, 1);
    taps(K_RIGHT, 1);
    chk("round", stored_a, 16'h9010);
    round_en = 1'h0;
    val_max = 16'h8000;
    taps(K_SET, 1);
    taps(K_DOWN, 1);
    taps(K_SET, 1);
    chk("reject", 16'(n_rej), 16'h1);
    taps(K_SET, 1);
    taps(K_DOWN, 1);
    taps(K_ABORT, 1);
    chk("kept", stored_a, 16'h9010);
    val_max = 16'hffff;
    chk("dp dec", 16'(dp_off), 16'h0);
    edit_hex = 1'h1;
    taps(K_SET, 1);
    chk("dp", 16'(dp_off), 16'h1);
    taps(K_RIGHT, 2);
    taps(K_DOWN, 2);
    chk("wrapF", disp_val, 16'h90f0);
    taps(K_ABORT, 1);
    edit_hex = 1'h0;
    edit_pf = 1'h1;
    taps(K_SET, 1);
    taps(K_DOWN, 1);
    chk("pf one", disp_val, 16'h0100);
    taps(K_DOWN, 1);
    chk("pf zero", disp_val, 16'h0099);
    taps(K_ABORT, 1);
    edit_pf = 1'h0;
    $display("test edit done");
  endtask

  task automatic t_tmo;
    taps(K_SET, 1);
    longterm_busy = 1'h1;
    repeat (250) @(posedge clk_sys);
    #1 longterm_busy = 1'h0;
    result_busy = 1'h1;
    repeat (250) @(posedge clk_sys);
    #1 result_busy = 1'h0;
    chk("busy hold", 16'(edit_active), 16'h1);
    repeat (210) @(posedge clk_sys);
    #1;
    chk("tmo", 16'(edit_active), 16'h0);
    chk("tmo std", 16'(ribbon_pos), 16'(RB_PF));
    $display("test timeout done");
  endtask

  task automatic t_pair_list;
    taps(K_DOWN, 5);
    edit_pair = 1'h1;
    taps(K_SET, 1);
    taps(K_DOWN, 1);
    taps(K_SET, 1);
    chk("pend", 16'(pair_pending), 16'h1);
    chk("half", stored_a, 16'h9010);
    chk("half b", stored_b, 16'h0000);
    taps(K_SET, 2);
    chk("pair", stored_a, 16'h8010);
    chk("pair b", stored_b, 16'h9010);
    chk("ratio", 16'(basis_two_dec), 16'h0);
    edit_pair = 1'h0;
    edit_list = 1'h1;
    taps(K_SET, 1);
    chk("lblink", 16'(digit_blink), 16'h1);
    taps(K_DOWN, 3);
    chk("lwrap", disp_val, 16'h0);
    taps(K_DOWN, 1);
    taps(K_SET, 1);
    chk("lset", stored_a, 16'h1);
    edit_list = 1'h0;
    $display("test pair list done");
  endtask

  task automatic t_modes;
    strobe(3'h1);
    taps(K_ABORT, 1);
    chk("hand std", 16'(ribbon_pos), 16'(RB_HAND));
    taps(K_ABORT, 1);
    chk("hand end", 16'(op_mode), 16'(MODE_REG));
    strobe(3'h2);
    taps(K_ABORT, 1);
    chk("comm std", 16'(ribbon_pos), 16'(RB_VOLT));
    taps(K_DOWN, 1);
    chk("ratio blink", 16'(whole_blink), 16'h0);
    taps(K_DOWN, 4);
    chk("comm skip", 16'(ribbon_pos), 16'(RB_VOLT));
    strobe(3'h4);
    chk("comm done", 16'(op_mode), 16'(MODE_REG));
    rstn = 1'h0;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'h1;
    chk("rst basis", 16'(basis_two_dec), 16'h1);
    chk("rst pair", stored_b, 16'(VAL_RST));
    $display("test modes done");
  endtask

  initial begin
    rstn = 1'h0;
    go = 1'h0;
    keys = 4'h0;
    hold = 8'h02;
    {hand_enter, comm_start, comm_done, longterm_busy, result_busy} = 5'h00;
    {edit_list, edit_hex, edit_pf, edit_pair, round_en} = 5'h00;
    val_min = 16'h0000;
    val_max = 16'hffff;
    list_len = 4'h3;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'h1;
    t_reset();
    t_chord();
    t_info();
    t_edit();
    t_tmo();
    t_pair_list();
    t_modes();
    final_report();
  end
endmodule

// ===== verification/keypad_operator.sv
// operator model: holds a key set for a commanded number of cycles
// assumes the bench raises go for one cycle and waits for busy to fall
`timescale 1ns/1ps
module keypad_operator (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [3:0] keys,
  input wire logic [7:0] hold,
  output logic busy,
  output logic abort_key,
  output logic down_key,
  output logic right_key,
  output logic set_key
);
  logic [3:0] held;
  assign {set_key, right_key, down_key, abort_key} = held;
  initial begin
    busy = 1'h0;
    held = 4'h0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        #1 busy = 1'h1;
        held = keys;
        repeat (hold) @(posedge clk_sys);
        #1 held = 4'h0;
        // quiet gap so the release-triggered action lands before the next press
        repeat (3) @(posedge clk_sys);
        #1 busy = 1'h0;
      end
    end
  end
endmodule

// ===== verilog/keypad_menu_number_entry.sv
// four-key panel decoder, readings-tree cursor, number and list editors
// assumes keys are synchronous levels, high while pressed
// Summary of operation
// - four keys decoded independently, chords allowed
// - abort cancels, climbs, or ends hand mode
// - matrix: down next series, right next category
// - step cursor right, passes all between 8,1
// - abort+set held 3 s: emergency stop
// - both arrows held: reset, restart after stop
// - hex values shown, decimal point suppressed
// - down decrements blinking digit, wraps to max
// - right next digit; last right/set submits
// - accepted value rounded to internal scale
// - bad value or abort keeps old value
// - three idle minutes return standard screen
// - skip invalid figures; power factor fraction forcing
// - pair commits only when both halves accepted
// - improper items blink; unset ratio basis
// - list: last digit blinks, down cycles
// - standard position depends on operating mode
// - readings tree never changes stored values
// - top level right steps five groups, led
// - down/set enter group; right walks items
// - wrap passes higher ribbon, except level three
// - abort climbs one level, four reach standard
`timescale 1ns/1ps
module keypad_menu_number_entry #(
  parameter int LONG_CYCLES = keypad_menu_pkg::LONG_CYC,
  parameter int TMO_CYCLES = keypad_menu_pkg::TMO_CYC
) (
  input logic clk_sys,
  input logic rstn,
  input logic abort_key,
  input logic down_key,
  input logic right_key,
  input logic set_key,
  input logic hand_enter,
  input logic comm_start,
  input logic comm_done,
  input logic longterm_busy,
  input logic result_busy,
  input logic edit_list,
  input logic edit_hex,
  input logic edit_pf,
  input logic edit_pair,
  input logic round_en,
  input logic [15:0] val_min,
  input logic [15:0] val_max,
  input logic [3:0] list_len,
  output keypad_menu_pkg::op_mode_t op_mode,
  output keypad_menu_pkg::ribbon_t ribbon_pos,
  output logic [1:0] menu_level,
  output logic [2:0] menu_group,
  output logic [2:0] menu_series,
  output logic [3:0] menu_item,
  output logic on_upper_ribbon,
  output logic info_led_blink,
  output logic steps_all,
  output logic edit_active,
  output logic [15:0] disp_val,
  output logic [3:0] digit_blink,
  output logic whole_blink,
  output logic dp_off,
  output logic basis_two_dec,
  output logic [15:0] stored_a,
  output logic [15:0] stored_b,
  output logic pair_pending,
  output logic estop_pulse,
  output logic reset_pulse,
  output logic reject_pulse
);
  import keypad_menu_pkg::*;

  localparam logic [31:0] LONG_M1 = 32'(LONG_CYCLES - 1);
  localparam logic [31:0] TMO_M1 = 32'(TMO_CYCLES - 1);

  typedef struct packed {
    op_mode_t mode;
    ribbon_t rb;
    logic [1:0] lvl;
    logic [2:0] grp;
    logic [2:0] ser;
    logic [3:0] itm;
    logic up;
    edit_t ed;
    logic [1:0] dig;
    logic [15:0] edval;
    logic [3:0] lidx;
    logic half;
    logic [15:0] pend;
    logic [15:0] sa;
    logic [15:0] sb;
    logic ratio_ok;
    logic [3:0] prev;
    logic [3:0] seen;
    logic used;
    logic [31:0] cnt;
    logic [31:0] idle;
    logic estop;
    logic rstp;
    logic rej;
  } state_t;

  state_t s_ff, nxt_s;
  logic [3:0] held;
  logic [3:0] ev;

  function automatic ribbon_t std_rb(input op_mode_t m);
    case (m)
      MODE_HAND: std_rb = RB_HAND;
      MODE_COMM: std_rb = RB_VOLT;
      default: std_rb = RB_PF;
    endcase
  endfunction

  function automatic ribbon_t rb_next(input ribbon_t r, input op_mode_t m);
    ribbon_t t;
    t = (r == RB_EDIT) ? RB_PF : ribbon_t'(r + 3'h1);
    if (m == MODE_COMM && t == RB_PF) begin
      t = RB_VOLT;
    end
    rb_next = t;
  endfunction

  function automatic logic [3:0] step_next(input logic [2:0] g, input logic [3:0] i);
    if (g == GRP_STEPS) begin
      step_next = (i == STEP_LAST) ? STEP_ALL : ((i == STEP_ALL) ? STEP_FIRST : i + 4'h1);
    end else begin
      step_next = (i == ITEM_LAST) ? 4'h0 : i + 4'h1;
    end
  endfunction

  function automatic logic [15:0] dec_digit(input logic [15:0] v, input logic [1:0] i,
                                             input logic hex, input logic pf);
    logic [15:0] r;
    logic [3:0] d;
    logic [3:0] m;
    r = v;
    d = v[{i, 2'b00} +: 4];
    m = hex ? DIG_HEX_MAX : DIG_DEC_MAX;
    if (pf && i == DIG_PF_INT) begin
      m = PF_INT_MAX;
    end
    d = (d == 4'h0 || d > m) ? m : d - 4'h1;
    r[{i, 2'b00} +: 4] = d;
    if (pf && i == DIG_PF_INT) begin
      r[7:0] = (d == PF_INT_MAX) ? 8'h00 : PF_FRAC_HI;
    end
    dec_digit = r;
  endfunction

  // nearest multiple of five in the last decimal digit, carry rippled up
  function automatic logic [15:0] round5(input logic [15:0] v);
    logic [15:0] r;
    logic c;
    r = v;
    c = 1'b0;
    if (v[3:0] < 4'h3) begin
      r[3:0] = 4'h0;
    end else if (v[3:0] < 4'h8) begin
      r[3:0] = 4'h5;
    end else begin
      r[3:0] = 4'h0;
      c = 1'b1;
    end
    for (int k = 1; k < 4; k++) begin
      if (c) begin
        c = (r[4*k +: 4] == DIG_DEC_MAX);
        r[4*k +: 4] = c ? 4'h0 : r[4*k +: 4] + 4'h1;
      end
    end
    round5 = r;
  endfunction

  assign held = {set_key, right_key, down_key, abort_key};
  // single action only on full release of a lone key, so chords never leak
  assign ev = (held == 4'h0 && s_ff.prev != 4'h0 && !s_ff.used &&
               $onehot(s_ff.seen)) ? s_ff.seen : 4'h0;

  always_comb begin
    logic acc;
    logic [15:0] v;
    acc = 1'b0;
    v = s_ff.edval;
    nxt_s = s_ff;
    nxt_s.estop = 1'b0;
    nxt_s.rstp = 1'b0;
    nxt_s.rej = 1'b0;
    nxt_s.prev = held;
    nxt_s.seen = (held == 4'h0) ? 4'h0 : (s_ff.seen | held);
    nxt_s.used = (held == 4'h0) ? 1'b0 : s_ff.used;
    nxt_s.cnt = (held != s_ff.prev) ? 32'h0000_0000 : s_ff.cnt + 32'h0000_0001;
    nxt_s.idle = (held != 4'h0 || longterm_busy || result_busy) ? 32'h0000_0000 :
                 s_ff.idle + 32'h0000_0001;
    if (hand_enter) begin
      nxt_s.mode = MODE_HAND;
    end else if (comm_start) begin
      nxt_s.mode = MODE_COMM;
    end else if (comm_done && s_ff.mode == MODE_COMM) begin
      nxt_s.mode = MODE_REG;
    end
    if (!s_ff.used && held == s_ff.prev && s_ff.cnt == LONG_M1 &&
        (held == CHORD_STOP || held == CHORD_RESET)) begin
      nxt_s.used = 1'b1;
      nxt_s.mode = (held == CHORD_STOP) ? MODE_STOP : MODE_REG;
      nxt_s.estop = (held == CHORD_STOP);
      nxt_s.rstp = (held == CHORD_RESET);
      nxt_s.lvl = 2'h0;
      nxt_s.up = 1'b0;
      nxt_s.ed = ED_NONE;
      nxt_s.half = 1'b0;
      nxt_s.rb = std_rb(nxt_s.mode);
    end else if (s_ff.idle == TMO_M1) begin
      nxt_s.lvl = 2'h0;
      nxt_s.up = 1'b0;
      nxt_s.ed = ED_NONE;
      nxt_s.half = 1'b0;
      nxt_s.rb = std_rb(s_ff.mode);
    end else if (ev != 4'h0) begin
      case (s_ff.ed)
        ED_NUM: begin
          if (ev == K_DOWN) begin
            nxt_s.edval = dec_digit(s_ff.edval, s_ff.dig, edit_hex, edit_pf);
          end else if (ev == K_RIGHT && s_ff.dig != 2'h0) begin
            nxt_s.dig = s_ff.dig - 2'h1;
          end else if (ev == K_RIGHT || ev == K_SET) begin
            acc = 1'b1;
          end else if (ev == K_ABORT) begin
            nxt_s.ed = ED_NONE;
            nxt_s.half = 1'b0;
          end
        end
        ED_LIST: begin
          if (ev == K_DOWN) begin
            nxt_s.lidx = (s_ff.lidx + 4'h1 >= list_len) ? 4'h0 : s_ff.lidx + 4'h1;
          end else if (ev == K_SET) begin
            nxt_s.ed = ED_NONE;
            nxt_s.sa = {12'h000, s_ff.lidx};
          end else if (ev == K_ABORT) begin
            nxt_s.ed = ED_NONE;
          end
        end
        default: begin
          case (s_ff.lvl)
            2'h0: begin
              if (ev == K_ABORT) begin
                if (s_ff.rb == RB_HAND && s_ff.mode == MODE_HAND) begin
                  nxt_s.mode = MODE_REG;
                end
                nxt_s.half = 1'b0;
                nxt_s.rb = std_rb(nxt_s.mode);
              end else if (ev == K_DOWN) begin
                nxt_s.rb = rb_next(s_ff.rb, s_ff.mode);
              end else if (s_ff.rb == RB_INFO) begin
                nxt_s.lvl = 2'h1;
                nxt_s.grp = code_table_readings_group;
              end else if (ev == K_SET && s_ff.rb == RB_EDIT) begin
                nxt_s.ed = edit_list ? ED_LIST : ED_NUM;
                nxt_s.edval = edit_pf ? {4'h0, s_ff.sa[11:0]} : s_ff.sa;
                nxt_s.dig = edit_pf ? DIG_PF_INT : 2'h3;
                nxt_s.lidx = 4'h0;
              end
            end
            2'h1: begin
              if (ev == K_ABORT) begin
                nxt_s.lvl = 2'h0;
                nxt_s.up = 1'b0;
              end else if (ev == K_RIGHT) begin
                nxt_s.up = !s_ff.up && s_ff.grp == GRP_LAST;
                nxt_s.grp = (s_ff.up || s_ff.grp == GRP_LAST) ? 3'h0 : s_ff.grp + 3'h1;
              end else if (s_ff.up) begin
                nxt_s.up = 1'b0;
                if (ev == K_DOWN) begin
                  nxt_s.lvl = 2'h0;
                  nxt_s.rb = rb_next(RB_INFO, s_ff.mode);
                end
              end else begin
                nxt_s.lvl = 2'h2;
                nxt_s.ser = 3'h0;
              end
            end
            2'h2: begin
              if (ev == K_ABORT) begin
                nxt_s.lvl = 2'h1;
                nxt_s.up = 1'b0;
              end else if (s_ff.up && ev == K_RIGHT) begin
                nxt_s.lvl = 2'h1;
                nxt_s.up = 1'b0;
                nxt_s.grp = (s_ff.grp == GRP_LAST) ? 3'h0 : s_ff.grp + 3'h1;
              end else if (ev == K_DOWN) begin
                nxt_s.up = !s_ff.up && s_ff.ser == ((s_ff.grp == code_table_readings_group) ?
                           SER_LAST_1D : SER_LAST_2D);
                nxt_s.ser = (s_ff.up || nxt_s.up) ? 3'h0 : s_ff.ser + 3'h1;
              end else if (!s_ff.up && s_ff.grp != code_table_readings_group) begin
                nxt_s.lvl = 2'h3;
                nxt_s.itm = (s_ff.grp == GRP_STEPS) ? STEP_FIRST : 4'h0;
              end
            end
            default: begin
              if (ev == K_ABORT) begin
                nxt_s.lvl = 2'h2;
              end else if (ev == K_RIGHT) begin
                nxt_s.itm = step_next(s_ff.grp, s_ff.itm);
              end else if (ev == K_DOWN) begin
                nxt_s.ser = (s_ff.ser == SER_LAST_2D) ? 3'h0 : s_ff.ser + 3'h1;
              end
            end
          endcase
        end
      endcase
    end
    if (acc) begin
      nxt_s.ed = ED_NONE;
      if (v < val_min || v > val_max) begin
        nxt_s.rej = 1'b1;
        nxt_s.half = 1'b0;
      end else begin
        v = (round_en && !edit_hex) ? round5(v) : v;
        if (edit_pair && !s_ff.half) begin
          nxt_s.half = 1'b1;
          nxt_s.pend = v;
        end else if (edit_pair) begin
          nxt_s.half = 1'b0;
          nxt_s.sa = s_ff.pend;
          nxt_s.sb = v;
          nxt_s.ratio_ok = 1'b1;
        end else begin
          nxt_s.sa = v;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_ff <= '0;
      s_ff.mode <= MODE_REG;
      s_ff.rb <= RB_PF;
      s_ff.ed <= ED_NONE;
      s_ff.sa <= VAL_RST;
      s_ff.sb <= VAL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign op_mode = s_ff.mode;
  assign ribbon_pos = s_ff.rb;
  assign menu_level = s_ff.lvl;
  assign menu_group = s_ff.grp;
  assign menu_series = s_ff.ser;
  assign menu_item = s_ff.itm;
  assign on_upper_ribbon = s_ff.up;
  assign info_led_blink = (s_ff.lvl != 2'h0);
  assign steps_all = (s_ff.lvl == 2'h3 && s_ff.grp == GRP_STEPS && s_ff.itm == STEP_ALL);
  assign edit_active = (s_ff.ed != ED_NONE);
  assign disp_val = (s_ff.ed == ED_LIST) ? {12'h000, s_ff.lidx} :
                    ((s_ff.ed == ED_NUM) ? s_ff.edval : s_ff.sa);
  assign digit_blink = (s_ff.ed == ED_LIST) ? 4'h1 :
                       ((s_ff.ed == ED_NUM) ? (4'h1 << s_ff.dig) : 4'h0);
  assign whole_blink = !s_ff.ratio_ok && s_ff.lvl == 2'h0 && s_ff.rb == RB_CURR;
  assign basis_two_dec = !s_ff.ratio_ok;
  assign dp_off = edit_hex;
  assign stored_a = s_ff.sa;
  assign stored_b = s_ff.sb;
  assign pair_pending = s_ff.half;
  assign estop_pulse = s_ff.estop;
  assign reset_pulse = s_ff.rstp;
  assign reject_pulse = s_ff.rej;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_estop_hold: assert property (estop_pulse |->
    $past(s_ff.cnt) == LONG_M1 && $past(held) == CHORD_STOP && op_mode == MODE_STOP)
    else $error("stop without full chord hold");
  a_reset_mode: assert property (reset_pulse |-> op_mode == MODE_REG && menu_level == 2'h0)
    else $error("reset chord did not restart");
  a_single_key: assert property (held == 4'h0 && s_ff.prev != 4'h0 && !$onehot(s_ff.seen)
    |=> $stable(ribbon_pos) && $stable(menu_level) && $stable(edit_active))
    else $error("chord leaked a key action");
  a_tree_ro: assert property (menu_level != 2'h0 |=> $stable(stored_a) && $stable(stored_b))
    else $error("stored value changed in tree");
  a_reject_keep: assert property (reject_pulse |-> stored_a == $past(stored_a))
    else $error("rejected value stored");
  a_idle_std: assert property (s_ff.idle == TMO_M1 && !estop_pulse ##1 !reset_pulse |->
    menu_level == 2'h0 && !edit_active && ribbon_pos == std_rb(op_mode))
    else $error("timeout missed standard screen");
  a_step_wrap: assert property (menu_level == 2'h3 && menu_group == GRP_STEPS &&
    menu_item == STEP_LAST && ev == K_RIGHT && s_ff.idle != TMO_M1 |=> steps_all)
    else $error("step wrap skipped all position");
  a_pf_force: assert property (s_ff.ed == ED_NUM && edit_pf && s_ff.dig == DIG_PF_INT &&
    ev == K_DOWN && s_ff.edval[11:8] == 4'h0 && s_ff.idle != TMO_M1 && s_ff.cnt != LONG_M1
    |=> s_ff.edval[11:0] == 12'h100)
    else $error("power factor fraction not forced");
  a_pair_half: assert property ($rose(pair_pending) |-> $stable(stored_a) && $stable(stored_b))
    else $error("half pair committed");
  a_level_wrap: assert property (menu_level == 2'h1 && menu_group == GRP_LAST && !on_upper_ribbon &&
    ev == K_RIGHT && s_ff.idle != TMO_M1 && s_ff.cnt != LONG_M1 |=> on_upper_ribbon)
    else $error("no intermediate ribbon state");

  c_estop: cover property (estop_pulse);
  c_pair_commit: cover property ($fell(pair_pending) && !reject_pulse);
  c_step_all: cover property (steps_all);
  c_reject: cover property (reject_pulse);
endmodule
